// >>> src/sps_pkg.sv
// constants and types shared by the pair sequencer design
package sps_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int STK_N      = 32;
  localparam int IDX_W      = 5;
  localparam int LAYER_W    = 9;
  localparam int SEL_W      = 4;
  localparam int RES_W      = 14;
  localparam int WORD_W     = 16;
  localparam int AV_AW      = 7;
  localparam int AV_DW      = 32;
  localparam int CRC_W      = 8;
  localparam int DEF_LAYERS = 8;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [AV_AW-1:0] STACK_BASE_IDX = 7'h20;
  localparam logic [AV_AW-1:0] STACK_LAST_IDX = 7'h3f;
  localparam logic [AV_AW-1:0] CTRL_IDX       = 7'h02;
  localparam logic [AV_AW-1:0] STATUS_IDX     = 7'h03;
  localparam logic [AV_AW-1:0] POINTER_IDX    = 7'h04;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int A_SEL_LSB  = 0;
  localparam int B_SEL_LSB  = 4;
  localparam int LAST_BIT   = 8;
  localparam int ADDR_LSB   = 9;
  localparam int CTRL_STAT  = 0;
  localparam int CTRL_CRC   = 1;
  localparam int CTRL_RUN   = 2;
  localparam int CTRL_RLD   = 3;
  localparam logic [2:0]         CTRL_RESET   = 3'h0;
  localparam logic [WORD_W-1:0]  STATUS_RESET = 16'h0000;
  localparam logic [LAYER_W-1:0] LAYER_ZERO   = 9'h000;

  // ---------------------------------------------------------------
  // selection codes and self-test values
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_SUPPLY   = 4'h8;
  localparam logic [SEL_W-1:0] SEL_REGOUT   = 4'h9;
  localparam logic [SEL_W-1:0] SEL_SELFTEST = 4'hb;
  localparam logic [RES_W-1:0] SELFTEST_A   = 14'h2aaa;
  localparam logic [RES_W-1:0] SELFTEST_B   = 14'h1555;
  localparam logic [CRC_W-1:0] CRC_POLY     = 8'h07;
  localparam logic [CRC_W-1:0] CRC_INIT     = 8'h00;

  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_ACK} sps_bus_t;
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_CONV, S_OUT_B, S_OUT_ST
  } sps_seq_t;

endpackage

// >>> src/sps_stack_if.sv
// stack memory ports between the sequencer top and its layer store
`timescale 1ns/1ps
interface sps_stack_if;
  import sps_pkg::*;
  logic                 wr_en;
  logic [IDX_W-1:0]     wr_idx;
  logic [LAYER_W-1:0]   wr_data;
  logic                 reload;
  logic [IDX_W-1:0]     rd_idx_bus;
  logic [LAYER_W-1:0]   rd_data_bus;
  logic [IDX_W-1:0]     rd_idx_seq;
  logic [LAYER_W-1:0]   rd_data_seq;

  modport mem (input wr_en, wr_idx, wr_data, reload, rd_idx_bus,
               rd_idx_seq, output rd_data_bus, rd_data_seq);
  modport ctl (output wr_en, wr_idx, wr_data, reload, rd_idx_bus,
               rd_idx_seq, input rd_data_bus, rd_data_seq);
endinterface

// >>> src/sps_stack_mem.sv
// thirty-two layer stack store with registered read ports
`timescale 1ns/1ps
module sps_stack_mem
  import sps_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic ce,
  sps_stack_if.mem  sif
);

  logic [LAYER_W-1:0] layer_q [STK_N];

  // ---------------------------------------------------------------
  // default contents: pairs 0..7, layer 7 closes the loop
  // ---------------------------------------------------------------
  function automatic logic [LAYER_W-1:0] layer_init(input int i);
    logic [SEL_W-1:0] code;
    code = SEL_W'(i);
    if (i < DEF_LAYERS) begin
      layer_init = {(i == DEF_LAYERS - 1), code, code};
    end else begin
      layer_init = LAYER_ZERO;
    end
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < STK_N; i++) begin : g_layer
    always_ff @(posedge clock) begin
      if (srst) begin
        layer_q[i] <= layer_init(i);
      end else if (ce) begin
        if (sif.reload) begin
          layer_q[i] <= layer_init(i);
        end else if (sif.wr_en && sif.wr_idx == IDX_W'(i)) begin
          layer_q[i] <= sif.wr_data;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sif.rd_data_bus <= LAYER_ZERO;
      sif.rd_data_seq <= LAYER_ZERO;
    end else if (ce) begin
      sif.rd_data_bus <= layer_q[sif.rd_idx_bus];
      sif.rd_data_seq <= layer_q[sif.rd_idx_seq];
    end
  end

  a_reload_defaults: assert property (@(posedge clock) disable iff (srst)
    sif.reload && ce |=> layer_q[0] == 9'h000 && layer_q[7] == 9'h177
      && layer_q[8] == 9'h000)
    else $error("stack defaults not restored by reload");

endmodule

// >>> src/sps_crc8.sv
// eight-bit crc over one result pair, registered on load
`timescale 1ns/1ps
module sps_crc8
  import sps_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic                 load,
  input  wire logic [2*WORD_W-1:0]  data,
  output logic      [CRC_W-1:0]     crc_q
);

  logic [CRC_W-1:0] crc_d;

  // msb first, one bit per step; a whole pair settles in one cycle
  always_comb begin
    crc_d = CRC_INIT;
    for (int b = 2 * WORD_W - 1; b >= 0; b--) begin
      if (crc_d[CRC_W-1] ^ data[b]) begin
        crc_d = {crc_d[CRC_W-2:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc_d = {crc_d[CRC_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      crc_q <= CRC_INIT;
    end else if (ce && load) begin
      crc_q <= crc_d;
    end
  end

endmodule

// >>> src/sps_seq_top.sv
// channel-pair sequencer with status word and avalon register slave
//
// Operation
// - stack-select bit set: five-bit index picks 1 of 32 layers.
// - a layer holds an A and a B input, sampled together when reached.
// - sequence starts at the first layer and steps towards layer 32.
// - a layer whose last-layer flag is 0 is followed by the next layer.
// - a set last flag (bit 8) ends the sequence, then layer 0 follows.
// - reset reloads pairs 0-7 into layers 0-7 and zeroes the other 24.
// - stack word bits 15 to 9 carry its register address for decoding.
// - code 0-7 is an input, 8 supply, 9 regulator; 10 and 12 are reserved.
// - code 1011 is self test: A reads 0x2aaa and B reads 0x1555.
// - A selection sits in bits 3 to 0 and uses the same codes as B.
// - status or crc enable puts the status word after all result words.
// - status bits 15 to 12 hold the channel of the previous A result.
// - status bits 11 to 8 hold the channel of the previous B result.
// - status bits 7 to 0 give a crc over the previous results.
// - the 32 layers sit at consecutive indices 0x20 to 0x3f.
`timescale 1ns/1ps
module sps_seq_top
  import sps_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [AV_AW-1:0]  avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [AV_DW-1:0]  avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [AV_DW-1:0]  avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              conv_trigger,
  output logic                   conv_req,
  output logic      [SEL_W-1:0]  conv_sel_a,
  output logic      [SEL_W-1:0]  conv_sel_b,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result_a,
  input  wire logic [RES_W-1:0]  conv_result_b,
  output logic                   word_valid,
  output logic      [WORD_W-1:0] word_data,
  output logic                   word_last
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sps_stack_if sif ();

  sps_bus_t             bus_q;
  sps_seq_t             seq_q;
  logic [2:0]           ctrl_q;
  logic                 reload_q;
  logic [IDX_W-1:0]     ptr_q;
  logic                 last_q;
  logic [WORD_W-1:0]    status_q;
  logic [RES_W-1:0]     res_b_q;
  logic                 trig_s1_q;
  logic                 trig_s2_q;
  logic                 trig_s3_q;
  logic                 stack_hit;
  logic                 req;
  logic                 trig_edge;
  logic                 append_en;
  logic [RES_W-1:0]     res_a_d;
  logic [RES_W-1:0]     res_b_d;
  logic [CRC_W-1:0]     crc_q;
  logic [AV_DW-1:0]     rdata_d;

  // ---------------------------------------------------------------
  // address decode and stack port wiring
  // ---------------------------------------------------------------
  // index bits 6:5 equal to 01 select the stack, so 0x20..0x3f map straight on
  assign stack_hit = avs_address[AV_AW-1:IDX_W] ==
                     STACK_BASE_IDX[AV_AW-1:IDX_W];
  assign req       = avs_read || avs_write;
  assign append_en = ctrl_q[CTRL_STAT] || ctrl_q[CTRL_CRC];

  assign sif.rd_idx_bus = avs_address[IDX_W-1:0];
  assign sif.rd_idx_seq = ptr_q;
  assign sif.wr_idx     = avs_address[IDX_W-1:0];
  assign sif.wr_data    = avs_writedata[LAYER_W-1:0];
  assign sif.reload     = reload_q;
  // a word whose address bits disagree with the slot is dropped
  assign sif.wr_en = bus_q == B_ACK && avs_write && stack_hit
                     && avs_byteenable[1:0] == 2'b11
                     && avs_writedata[WORD_W-1:ADDR_LSB] ==
                        avs_address;

  sps_stack_mem u_mem (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .sif   (sif.mem)
  );

  sps_crc8 u_crc (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .load  (seq_q == S_CONV && conv_done),
    .data  ({2'b00, res_a_d, 2'b00, res_b_d}),
    .crc_q (crc_q)
  );

  // ---------------------------------------------------------------
  // register slave: idle, one wait cycle, acknowledge
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (stack_hit) begin
      rdata_d[WORD_W-1:0] = {avs_address, sif.rd_data_bus};
    end else if (avs_address == CTRL_IDX) begin
      rdata_d[2:0] = ctrl_q;
    end else if (avs_address == STATUS_IDX) begin
      rdata_d[WORD_W-1:0] = status_q;
    end else if (avs_address == POINTER_IDX) begin
      rdata_d[IDX_W-1:0] = ptr_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bus_q           <= B_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if (ce) begin
      case (bus_q)
        B_IDLE: begin
          if (req) begin
            bus_q <= B_WAIT;
          end
        end
        B_WAIT: begin
          // memory read data became valid at the edge that entered B_WAIT
          bus_q           <= B_ACK;
          avs_waitrequest <= 1'b0;
          avs_readdata    <= avs_read ? rdata_d : '0;
        end
        B_ACK: begin
          bus_q           <= B_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q           <= B_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q   <= CTRL_RESET;
      reload_q <= 1'b0;
    end else if (ce) begin
      reload_q <= 1'b0;
      if (bus_q == B_ACK && avs_write && avs_address == CTRL_IDX
          && avs_byteenable[0]) begin
        ctrl_q   <= avs_writedata[2:0];
        reload_q <= avs_writedata[CTRL_RLD];
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else if (ce) begin
      trig_s1_q <= conv_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign trig_edge = trig_s2_q && !trig_s3_q;

  // ---------------------------------------------------------------
  // self-test substitution
  // ---------------------------------------------------------------
  // codes 0..9 pass to the mux unchanged; reserved codes convert as is
  assign res_a_d = (conv_sel_a == SEL_SELFTEST) ? SELFTEST_A
                                                : conv_result_a;
  assign res_b_d = (conv_sel_b == SEL_SELFTEST) ? SELFTEST_B
                                                : conv_result_b;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      seq_q      <= S_IDLE;
      ptr_q      <= '0;
      last_q     <= 1'b0;
      conv_req   <= 1'b0;
      conv_sel_a <= '0;
      conv_sel_b <= '0;
      res_b_q    <= '0;
      word_valid <= 1'b0;
      word_data  <= '0;
      word_last  <= 1'b0;
      status_q   <= STATUS_RESET;
    end else if (ce) begin
      word_valid <= 1'b0;
      word_last  <= 1'b0;
      conv_req   <= 1'b0;
      case (seq_q)
        S_IDLE: begin
          if (reload_q) begin
            ptr_q <= '0;
          end else if (trig_edge && ctrl_q[CTRL_RUN]) begin
            seq_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          conv_sel_a <= sif.rd_data_seq[A_SEL_LSB +: SEL_W];
          conv_sel_b <= sif.rd_data_seq[B_SEL_LSB +: SEL_W];
          last_q     <= sif.rd_data_seq[LAST_BIT];
          conv_req   <= 1'b1;
          seq_q      <= S_CONV;
        end
        S_CONV: begin
          if (conv_done) begin
            word_valid <= 1'b1;
            word_data  <= WORD_W'(res_a_d);
            res_b_q    <= res_b_d;
            if (last_q) begin
              ptr_q <= '0;
            end else begin
              ptr_q <= ptr_q + 1'b1;
            end
            seq_q <= S_OUT_B;
          end
        end
        S_OUT_B: begin
          word_valid <= 1'b1;
          word_data  <= WORD_W'(res_b_q);
          word_last  <= !append_en;
          status_q   <= {conv_sel_a, conv_sel_b, crc_q};
          seq_q      <= append_en ? S_OUT_ST : S_IDLE;
        end
        S_OUT_ST: begin
          word_valid <= 1'b1;
          word_data  <= status_q;
          word_last  <= 1'b1;
          seq_q      <= S_IDLE;
        end
        default: begin
          seq_q <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_stack_write_decode: assert property (
    sif.wr_en |-> avs_address[6:5] == 2'b01
      && sif.wr_idx == avs_address[4:0])
    else $error("stack write outside its decoded slot");

  a_stack_addr_field: assert property (
    bus_q == B_WAIT && avs_read && stack_hit && ce
      |=> !avs_waitrequest && avs_readdata[15:9] == $past(avs_address))
    else $error("stack read lacks its address bits");

  a_pair_request: assert property (
    $rose(conv_req) |-> conv_sel_a == $past(sif.rd_data_seq[3:0])
      && conv_sel_b == $past(sif.rd_data_seq[7:4]))
    else $error("requested pair differs from the layer");

  a_ptr_step: assert property (
    seq_q == S_CONV && conv_done && ce && !last_q
      |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("pointer did not step to the next layer");

  a_ptr_wrap: assert property (
    seq_q == S_CONV && conv_done && ce && last_q |=> ptr_q == 5'h00)
    else $error("pointer did not return to layer zero");

  a_selftest_words: assert property (
    seq_q == S_CONV && conv_done && ce && conv_sel_a == 4'hb
      && conv_sel_b == 4'hb ##1 ce
      |-> word_data == 16'h2aaa ##1 word_data == 16'h1555)
    else $error("self-test words wrong");

  a_status_tail: assert property (
    seq_q == S_OUT_B && ce && append_en ##1 ce
      |-> !word_last ##1 word_valid && word_last
      && word_data[15:12] == $past(conv_sel_a, 2)
      && word_data[11:8] == $past(conv_sel_b, 2))
    else $error("status word missing or wrong indices");

  a_status_crc: assert property (
    seq_q == S_OUT_ST && ce |=> word_data[7:0] == crc_q)
    else $error("status crc field wrong");

  a_no_status: assert property (
    seq_q == S_OUT_B && ce && !append_en |=> word_last && seq_q == S_IDLE)
    else $error("status word appended while disabled");

  c_wrap: cover property (seq_q == S_CONV && conv_done && last_q);
  c_status: cover property (seq_q == S_OUT_ST && ce);
  c_stack_write: cover property (sif.wr_en && ce);

endmodule

// >>> dv/sps_conv_model.sv
// converter pair model answering the sequencer's conversion requests
`timescale 1ns/1ps
module sps_conv_model
  import sps_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             slow,
  input  wire logic             conv_req,
  input  wire logic [SEL_W-1:0] sel_a,
  input  wire logic [SEL_W-1:0] sel_b,
  output logic                  done,
  output logic      [RES_W-1:0] res_a,
  output logic      [RES_W-1:0] res_b
);
  logic             busy_q;
  logic [3:0]       cnt_q;
  logic [SEL_W-1:0] a_q;
  logic [SEL_W-1:0] b_q;

  // results hold only in the done cycle; elsewhere they toggle so a
  // late sample of stale data shows up as a mismatch
  always_ff @(posedge clock) begin
    done  <= 1'b0;
    res_a <= ~res_a;
    res_b <= ~res_b;
    if (srst) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      res_a  <= 14'h0000;
      res_b  <= 14'h3fff;
    end else if (conv_req && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= slow ? 4'h6 : 4'h0;
      a_q    <= sel_a;
      b_q    <= sel_b;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      done   <= 1'b1;
      res_a  <= {a_q, 10'h155}; // pair answered together
      res_b  <= {b_q, 10'h0aa};
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the channel-pair sequencer
`timescale 1ns/1ps
module tb_top;
  import sps_pkg::*;
  logic              clock, srst, ce, slow, conv_trigger;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [AV_AW-1:0]  avs_address;
  logic [AV_DW-1:0]  avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic              conv_req, conv_done, word_valid, word_last;
  logic [SEL_W-1:0]  conv_sel_a, conv_sel_b;
  logic [RES_W-1:0]  conv_result_a, conv_result_b;
  logic [WORD_W-1:0] word_data;
  int                n_fail, checks_done;

  sps_seq_top sps_seq_top_inst (.clock(clock), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_trigger(conv_trigger),
    .conv_req(conv_req), .conv_sel_a(conv_sel_a),
    .conv_sel_b(conv_sel_b), .conv_done(conv_done),
    .conv_result_a(conv_result_a), .conv_result_b(conv_result_b),
    .word_valid(word_valid), .word_data(word_data),
    .word_last(word_last));

  sps_conv_model sps_conv_model_inst (.clock(clock), .srst(srst),
    .slow(slow), .conv_req(conv_req), .sel_a(conv_sel_a),
    .sel_b(conv_sel_b), .done(conv_done), .res_a(conv_result_a),
    .res_b(conv_result_b));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  function automatic logic [15:0] ra(input logic [3:0] s);
    return (s == 4'hb) ? 16'h2aaa : {2'b00, s, 10'h155};
  endfunction

  function automatic logic [15:0] rb(input logic [3:0] s);
    return (s == 4'hb) ? 16'h1555 : {2'b00, s, 10'h0aa};
  endfunction

  function automatic logic [31:0] lay(input int i, input logic l,
                                      input logic [3:0] b, input logic [3:0] a);
    return {16'h0000, 7'(32 + i), l, b, a};
  endfunction

  // request held up to the rising edge that samples waitrequest low;
  // a hang is left to the watchdog
  task automatic av(input logic wr, input logic [6:0] a,
                    input logic [31:0] d, input logic [3:0] be,
                    output logic [31:0] q);
    @(posedge clock);
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] q;
    av(1'b1, a, d, be, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  // one trigger, then the pair's words with optional status
  task automatic run_layer(input logic [3:0] sa, input logic [3:0] sb,
                           input logic st);
    logic [15:0] w [3];
    logic [2:0]  lst;
    logic [15:0] sw;
    int          k, n;
    sw = {sa, sb, crc8({ra(sa), rb(sb)})};
    w = '{16'h0, 16'h0, 16'h0};
    lst = 3'b000;
    @(posedge clock);
    conv_trigger <= 1'b1;
    @(posedge clock);
    conv_trigger <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (conv_req !== 1'b1 && n < 50);
    chk(conv_sel_a, sa);
    chk(conv_sel_b, sb);
    k = 0;
    n = 0;
    while (k < 3 && n < 60) begin
      @(negedge clock);
      n++;
      if (word_valid === 1'b1) begin
        w[k] = word_data;
        lst[k] = word_last;
        k++;
        if (word_last === 1'b1) n = 60;
      end
    end
    chk(k, st ? 3 : 2);
    chk(w[0], ra(sa));
    chk(w[1], rb(sb));
    chk(lst, st ? 3'b100 : 3'b010);
    if (st) chk(w[2], sw);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults;
    logic [3:0]  s;
    logic [31:0] e;
    for (int i = 0; i < STK_N; i++) begin
      s = (i < 8) ? 4'(i) : 4'h0;
      e = lay(i, i == 7, s, s);
      rd_chk(7'(32 + i), e);
    end
  endtask

  task automatic t_refuse;
    wr(7'h28, {16'h0000, 7'h29, 9'h1ff}, 4'hf);
    wr(7'h28, lay(8, 1'b1, 4'hf, 4'hf), 4'h1);
    rd_chk(7'h28, lay(8, 1'b0, 4'h0, 4'h0));
    rd_chk(7'h10, 32'h0000_0000);
  endtask

  task automatic t_sequence;
    logic [3:0] s8, s9;
    s8 = 4'h8;
    s9 = 4'h9;
    wr(7'h20, lay(0, 1'b0, 4'hb, 4'hb), 4'h3);
    wr(7'h21, lay(1, 1'b0, s9, s8), 4'h3);
    wr(7'h22, lay(2, 1'b1, 4'hc, 4'ha), 4'h3);
    wr(CTRL_IDX, 32'h5, 4'h1);
    run_layer(4'hb, 4'hb, 1'b1);
    run_layer(s8, s9, 1'b1);
    run_layer(4'ha, 4'hc, 1'b1);
    wr(CTRL_IDX, 32'h4, 4'h1);
    run_layer(4'hb, 4'hb, 1'b0);
    wr(CTRL_IDX, 32'h6, 4'h1);
    slow <= 1'b1;
    run_layer(s8, s9, 1'b1);
    slow <= 1'b0;
    rd_chk(STATUS_IDX, {16'h0, s8, s9, crc8({ra(s8), rb(s9)})});
  endtask

  task automatic t_reload;
    wr(CTRL_IDX, 32'h8, 4'h1);
    rd_chk(POINTER_IDX, 32'h0);
    rd_chk(7'h21, lay(1, 1'b0, 4'h1, 4'h1));
    rd_chk(7'h22, lay(2, 1'b0, 4'h2, 4'h2));
    wr(CTRL_IDX, 32'h4, 4'h1);
    for (int i = 0; i < 8; i++) run_layer(4'(i), 4'(i), 1'b0);
    run_layer(4'h0, 4'h0, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // whole run is a few hundred cycles; 25000 means a hang
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    conv_trigger = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    t_defaults();
    t_refuse();
    t_sequence();
    t_reload();
    end_sim();
  end
endmodule
